// ---- rtl/emb_pkg.sv ----
// Shared constants and types of the external memory bus decode block.
// Assumes one clock domain; every file of the block imports this package.
package emb_pkg;

  // ==========================================================
  // Register map on the special-function register port
  // ==========================================================
  localparam logic [7:0] EMB_WAIT_CONTROL_ADDR = 8'ha7;
  localparam logic [7:0] EMB_STATUS_ADDR       = 8'ha8;
  localparam int         EMB_WTEN_BIT          = 0;
  localparam int         EMB_WCKEN_BIT         = 1;
  localparam logic [1:0] EMB_WCTL_RESET        = 2'h0;
  localparam logic [7:0] EMB_UNMAPPED_DATA     = 8'h00;

  // ==========================================================
  // Configuration byte zero field positions
  // ==========================================================
  localparam int EMB_CFG_PAGE_BIT  = 0;
  localparam int EMB_CFG_REMAP_BIT = 1;
  localparam int EMB_CFG_MSEL_LO   = 2;
  localparam logic [1:0] EMB_CFG_SETTLE = 2'h3;

  // ==========================================================
  // Address map boundaries
  // ==========================================================
  localparam logic [7:0]  EMB_SEG_00      = 8'h00;
  localparam logic [7:0]  EMB_SEG_01      = 8'h01;
  localparam logic [7:0]  EMB_SEG_RSVD_LO = 8'h02;
  localparam logic [7:0]  EMB_SEG_RSVD_HI = 8'hfd;
  localparam logic [7:0]  EMB_SEG_FE      = 8'hfe;
  localparam logic [7:0]  EMB_SEG_FF      = 8'hff;
  localparam logic [23:0] EMB_REGFILE_TOP = 24'h00001f;
  localparam logic [23:0] EMB_RAM_BASE    = 24'h000020;
  localparam logic [23:0] EMB_BIT_TOP     = 24'h00007f;
  localparam logic [23:0] EMB_DIRECT_TOP  = 24'h00dfff;
  localparam logic [23:0] EMB_REMAP_BASE  = 24'h00e000;
  localparam logic [23:0] EMB_REMAP_DEST  = 24'hff2000;
  localparam logic [23:0] EMB_CODE_BASE   = 24'hff0000;
  localparam logic [23:0] EMB_CFG_BASE    = 24'hfffff8;
  localparam logic [23:0] EMB_DATA_TOP_11 = 24'h7fffff;
  localparam int          EMB_REMAP_BITS  = 13;
  localparam int          EMB_CODE_16K    = 16384;

  // ==========================================================
  // Enumerations
  // ==========================================================
  typedef enum logic [1:0] {
    EMB_SEL_256K   = 2'b00,
    EMB_SEL_128K   = 2'b01,
    EMB_SEL_64K_IO = 2'b10,
    EMB_SEL_64K_CMP = 2'b11
  } emb_msel_t;

  typedef enum logic [2:0] {
    EMB_RGN_REGFILE = 3'b000,
    EMB_RGN_RAM     = 3'b001,
    EMB_RGN_CODE    = 3'b010,
    EMB_RGN_EXT     = 3'b011,
    EMB_RGN_RSVD    = 3'b100,
    EMB_RGN_CFG     = 3'b101
  } emb_region_t;

  typedef enum logic [1:0] {
    EMB_AM_DIRECT   = 2'b00,
    EMB_AM_INDIRECT = 2'b01,
    EMB_AM_BIT      = 2'b10,
    EMB_AM_REGISTER = 2'b11
  } emb_amode_t;

  typedef enum logic [1:0] {
    EMB_ST_IDLE = 2'b00,
    EMB_ST_ADDR = 2'b01,
    EMB_ST_DATA = 2'b10
  } emb_state_t;

endpackage

// ---- rtl/emb_dec_if.sv ----
// Interface between the bus sequencer and the address map decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface emb_dec_if import emb_pkg::*; ();
  logic [23:0] addr;
  emb_amode_t  mode;
  logic        remap_n;
  logic        xacc_n;
  emb_region_t region;
  logic [23:0] eff_addr;
  logic        mode_ok;
  modport dec  (input addr, mode, remap_n, xacc_n,
                output region, eff_addr, mode_ok);
  modport user (output addr, mode, remap_n, xacc_n,
                input region, eff_addr, mode_ok);
endinterface
`default_nettype wire

// ---- rtl/emb_addr_decode.sv ----
// Address map decoder: region, effective address and mode legality.
// Assumes the caller holds the inputs stable while it uses the result.
`timescale 1ns/1ps
`default_nettype none
module emb_addr_decode import emb_pkg::*; #(
  parameter int CODE_BYTES = 16384,
  parameter int RAM_BYTES  = 1024
) (
  emb_dec_if.dec d
);
  localparam logic [23:0] RAM_TOP  =
    EMB_RAM_BASE + 24'(RAM_BYTES) - 24'h000001;
  localparam logic [23:0] CODE_TOP =
    EMB_CODE_BASE + 24'(CODE_BYTES) - 24'h000001;
  localparam logic HAS_CODE = (CODE_BYTES != 0);
  localparam logic HAS_REMAP = (CODE_BYTES == EMB_CODE_16K);

  // ==========================================================
  // Region decode
  // ==========================================================
  // Region first, then the mode check looks at the raw address.
  always_comb begin
    logic [7:0] seg;
    seg        = d.addr[23:16];
    d.region   = EMB_RGN_EXT;
    d.eff_addr = d.addr;
    if (seg == EMB_SEG_00) begin
      if (d.addr <= EMB_REGFILE_TOP) begin
        d.region = EMB_RGN_REGFILE;
      end else if (d.addr <= RAM_TOP) begin
        d.region = EMB_RGN_RAM;
      end else if (d.addr >= EMB_REMAP_BASE && HAS_REMAP &&
                   !d.remap_n && d.xacc_n) begin
        d.region   = EMB_RGN_CODE;
        d.eff_addr = EMB_REMAP_DEST |
                     {11'h000, d.addr[EMB_REMAP_BITS-1:0]};
      end
    end else if (seg >= EMB_SEG_RSVD_LO && seg <= EMB_SEG_RSVD_HI) begin
      d.region = EMB_RGN_RSVD;
    end else if (seg == EMB_SEG_FF) begin
      if (d.addr >= EMB_CFG_BASE) begin
        d.region = EMB_RGN_CFG;
      end else if (HAS_CODE && d.xacc_n && d.addr <= CODE_TOP) begin
        d.region = EMB_RGN_CODE;
      end
    end
    // Direct modes reach only region 00 below the remap window.
    unique case (d.mode)
      EMB_AM_DIRECT: begin
        d.mode_ok = (seg == EMB_SEG_00) &&
                    (d.addr <= EMB_DIRECT_TOP);
      end
      EMB_AM_INDIRECT: begin
        d.mode_ok = 1'b1;
      end
      EMB_AM_BIT: begin
        d.mode_ok = (d.addr >= EMB_RAM_BASE) &&
                    (d.addr <= EMB_BIT_TOP);
      end
      EMB_AM_REGISTER: begin
        d.mode_ok = (d.addr <= EMB_REGFILE_TOP);
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- rtl/emb_wait_clock.sv ----
// Wait clock generator: square wave at half the oscillator rate.
// Assumes the enable comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module emb_wait_clock import emb_pkg::*; (
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic enable_in,
  output logic      wclk_out
);
  typedef struct packed {
    logic wclk;
  } emb_wclk_state_t;

  emb_wclk_state_t s;
  emb_wclk_state_t next_s;

  // ==========================================================
  // Toggle flop
  // ==========================================================
  // Toggling every rising edge gives half the oscillator rate; parks low off.
  always_comb begin
    next_s.wclk = enable_in ? ~s.wclk : 1'b0;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wclk_out = s.wclk;

  property p_wclk_toggles;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (enable_in && $past(enable_in)) |-> (wclk_out != $past(wclk_out));
  endproperty
  a_wclk_toggles: assert property (p_wclk_toggles)
    else $error("wait clock failed to toggle while enabled");
endmodule
`default_nettype wire

// ---- rtl/emb_ext_memory_bus_decode.sv ----
// External memory bus sequencer, pin steering and wait control.
// Assumes the core issues one request at a time and holds no other
// bus master; configuration byte zero is valid from reset release.
//
// Notes on behaviour
// - Page mode: port 0 carries low address, port 2 high address and data.
// - Non-page mode: port 0 multiplexes low address and data, port 2 high.
// - Wait input is honoured only when wait control bit 0 is set.
// - Wait control bit 1 puts the wait clock on port 1 bit 7, except with select code 00, where that pin carries address 17.
// - Enabled wait clock is a square wave at half the oscillator rate.
// - Select field sets address width and which pins are freed.
// - Select field decides program, data read and write strobe coverage.
// - Top eight bytes of region FF hold configuration, not memory.
// - Region FF base maps to on-chip code up to its size.
// - Regions 02 to FD are reserved, undecoded, indeterminate data.
// - 16 KB parts with remap cleared map 00:E000 up to code FF:2000.
// - On-chip RAM from 00:0020 up to the RAM size.
// - Lowest 32 addresses of region 00 hold the register file.
// - Special function registers live in their own address space.
// - Low RAM allows bit addressing; up to 00:DFFF direct and indirect.
// - Regions 01, FE and FF allow indirect addressing only.
// - Select field comes from configuration byte zero at reset.
`timescale 1ns/1ps
`default_nettype none
module emb_ext_memory_bus_decode import emb_pkg::*; #(
  parameter int         CODE_BYTES  = 16384,
  parameter int         RAM_BYTES   = 1024,
  parameter logic [3:0] ADDR_CYCLES = 4'h2,
  parameter logic [3:0] DATA_CYCLES = 4'h4
) (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  config_byte_zero_in,
  input  wire logic        external_access_n_in,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [23:0] req_addr_in,
  input  wire logic [1:0]  req_mode_in,
  input  wire logic        req_write_in,
  input  wire logic [7:0]  req_wdata_in,
  output logic             resp_valid_out,
  output logic             resp_fault_out,
  output logic [2:0]       resp_region_out,
  output logic [23:0]      resp_addr_out,
  output logic [7:0]       resp_rdata_out,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic [7:0]  p0_in,
  output logic [7:0]       p0_out,
  output logic [7:0]       p0_oe_n_out,
  input  wire logic [7:0]  p2_in,
  output logic [7:0]       p2_out,
  output logic [7:0]       p2_oe_n_out,
  output logic             ale_out,
  output logic             program_read_strobe_n_out,
  output logic             write_strobe_n_out,
  input  wire logic        wait_n_in,
  input  wire logic        p1_7_port_in,
  input  wire logic        p1_7_port_oe_n_in,
  output logic             p1_7_out,
  output logic             p1_7_oe_n_out,
  input  wire logic        p3_7_port_in,
  input  wire logic        p3_7_port_oe_n_in,
  output logic             p3_7_out,
  output logic             p3_7_oe_n_out
);
  typedef struct packed {
    emb_state_t  st;
    logic [3:0]  cnt;
    logic [1:0]  cfg_cnt;
    logic        cfg_done;
    emb_msel_t   msel;
    logic        page;
    logic        remap_n;
    logic        xacc_n;
    logic [1:0]  wctl;
    logic        xacc_s1;
    logic        xacc_s2;
    logic        wait_s1;
    logic        wait_s2;
    logic [7:0]  p0_s1;
    logic [7:0]  p0_s2;
    logic [7:0]  p2_s1;
    logic [7:0]  p2_s2;
    logic [23:0] addr;
    logic        write;
    logic [7:0]  wdata;
    logic        rd_sel;
    logic        wr_ok;
    logic [7:0]  p0_q;
    logic        p0_drive;
    logic [7:0]  p2_q;
    logic        p2_drive;
    logic        a16;
    logic        a17;
    logic        ale;
    logic        prog_n;
    logic        rd_n;
    logic        wr_n;
    logic        resp_valid;
    logic        resp_fault;
    emb_region_t resp_region;
    logic [7:0]  resp_rdata;
    logic [7:0]  reg_rdata;
  } emb_top_state_t;

  localparam emb_top_state_t TOP_RESET = '{
    st: EMB_ST_IDLE, msel: EMB_SEL_256K, resp_region: EMB_RGN_REGFILE,
    wctl: EMB_WCTL_RESET, remap_n: 1'b1, xacc_n: 1'b1, xacc_s1: 1'b1,
    xacc_s2: 1'b1, wait_s1: 1'b1, wait_s2: 1'b1, prog_n: 1'b1,
    rd_n: 1'b1, wr_n: 1'b1, default: '0};

  emb_top_state_t s;
  emb_top_state_t next_s;
  logic           acc;
  logic           wclk;
  emb_dec_if      dec_bus ();

  // ==========================================================
  // Address map decoder and wait clock
  // ==========================================================
  assign dec_bus.addr    = req_addr_in;
  assign dec_bus.mode    = emb_amode_t'(req_mode_in);
  assign dec_bus.remap_n = s.remap_n;
  assign dec_bus.xacc_n  = s.xacc_n;

  emb_addr_decode #(
    .CODE_BYTES (CODE_BYTES),
    .RAM_BYTES  (RAM_BYTES)
  ) u_decode (
    .d (dec_bus.dec)
  );

  emb_wait_clock u_wclk (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .enable_in  (s.wctl[EMB_WCKEN_BIT]),
    .wclk_out   (wclk)
  );

  // A request is taken only once the configuration has been latched.
  assign acc = req_valid_in && (s.st == EMB_ST_IDLE) && s.cfg_done;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  // Pin values are set at phase changes so every bus pin comes from a flop.
  always_comb begin
    next_s = s;
    next_s.resp_valid = 1'b0;
    // Pin inputs pass two flops before anything looks at them.
    next_s.xacc_s1 = external_access_n_in;
    next_s.xacc_s2 = s.xacc_s1;
    next_s.wait_s1 = wait_n_in;
    next_s.wait_s2 = s.wait_s1;
    next_s.p0_s1   = p0_in;
    next_s.p0_s2   = s.p0_s1;
    next_s.p2_s1   = p2_in;
    next_s.p2_s2   = s.p2_s1;
    // Configuration is caught once after reset, never rewritten later.
    if (!s.cfg_done) begin
      if (s.cfg_cnt == EMB_CFG_SETTLE) begin
        next_s.cfg_done = 1'b1;
        next_s.msel     = emb_msel_t'(
          config_byte_zero_in[EMB_CFG_MSEL_LO +: 2]);
        next_s.page     = config_byte_zero_in[EMB_CFG_PAGE_BIT];
        next_s.remap_n  = config_byte_zero_in[EMB_CFG_REMAP_BIT];
        next_s.xacc_n   = s.xacc_s2;
      end else begin
        next_s.cfg_cnt = s.cfg_cnt + 2'h1;
      end
    end
    // The register port is its own space, apart from memory addresses.
    next_s.reg_rdata = EMB_UNMAPPED_DATA;
    if (reg_wr_in && reg_addr_in == EMB_WAIT_CONTROL_ADDR) begin
      next_s.wctl = reg_wdata_in[1:0];
    end
    if (reg_rd_in) begin
      if (reg_addr_in == EMB_WAIT_CONTROL_ADDR) begin
        next_s.reg_rdata = {6'h00, s.wctl};
      end else if (reg_addr_in == EMB_STATUS_ADDR) begin
        next_s.reg_rdata = {3'h0, s.wait_s2, (s.st != EMB_ST_IDLE),
                            s.page, s.msel};
      end
    end
    unique case (s.st)
      EMB_ST_IDLE: begin
        if (acc) begin
          next_s.addr        = dec_bus.eff_addr;
          next_s.write       = req_write_in;
          next_s.wdata       = req_wdata_in;
          next_s.resp_region = dec_bus.region;
          next_s.resp_fault  = !dec_bus.mode_ok;
          next_s.resp_rdata  = EMB_UNMAPPED_DATA;
          next_s.rd_sel = (s.msel == EMB_SEL_64K_CMP) &&
                          (dec_bus.eff_addr <= EMB_DATA_TOP_11);
          next_s.wr_ok  = (s.msel != EMB_SEL_64K_CMP) ||
                          (req_addr_in[23:16] == EMB_SEG_00);
          // Only legal external accesses that strobe start a cycle.
          if (dec_bus.mode_ok && dec_bus.region == EMB_RGN_EXT &&
              (!req_write_in || next_s.wr_ok)) begin
            next_s.st       = EMB_ST_ADDR;
            next_s.cnt      = ADDR_CYCLES - 4'h1;
            next_s.ale      = 1'b1;
            next_s.p0_q     = dec_bus.eff_addr[7:0];
            next_s.p0_drive = 1'b1;
            next_s.p2_q     = dec_bus.eff_addr[15:8];
            next_s.p2_drive = 1'b1;
            next_s.a16      = dec_bus.eff_addr[16];
            next_s.a17      = dec_bus.eff_addr[17];
          end else begin
            next_s.resp_valid = 1'b1;
          end
        end
      end
      EMB_ST_ADDR: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          next_s.st  = EMB_ST_DATA;
          next_s.cnt = DATA_CYCLES - 4'h1;
          next_s.ale = 1'b0;
          if (s.page) begin
            next_s.p2_q     = s.wdata;
            next_s.p2_drive = s.write;
          end else begin
            next_s.p0_q     = s.wdata;
            next_s.p0_drive = s.write;
          end
          next_s.wr_n   = !s.write;
          next_s.rd_n   = !(!s.write && s.rd_sel);
          next_s.prog_n = !(!s.write && !s.rd_sel);
        end
      end
      EMB_ST_DATA: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else if (!(s.wctl[EMB_WTEN_BIT] && !s.wait_s2)) begin
          // Held here while the enabled wait input is low.
          next_s.st         = EMB_ST_IDLE;
          next_s.resp_valid = 1'b1;
          next_s.resp_rdata = s.write ? EMB_UNMAPPED_DATA :
                              (s.page ? s.p2_s2 : s.p0_s2);
          next_s.wr_n       = 1'b1;
          next_s.rd_n       = 1'b1;
          next_s.prog_n     = 1'b1;
          next_s.p0_drive   = 1'b0;
          next_s.p2_drive   = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= TOP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs and shared pin steering
  // ==========================================================
  assign req_ready_out   = (s.st == EMB_ST_IDLE) && s.cfg_done;
  assign resp_valid_out  = s.resp_valid;
  assign resp_fault_out  = s.resp_fault;
  assign resp_region_out = s.resp_region;
  assign resp_addr_out   = s.addr;
  assign resp_rdata_out  = s.resp_rdata;
  assign reg_rdata_out   = s.reg_rdata;
  assign p0_out          = s.p0_q;
  assign p0_oe_n_out     = {8{!s.p0_drive}};
  assign p2_out          = s.p2_q;
  assign p2_oe_n_out     = {8{!s.p2_drive}};
  assign ale_out         = s.ale;
  assign program_read_strobe_n_out = s.prog_n;
  assign write_strobe_n_out        = s.wr_n;

  // Address 17 wins over the wait clock, which wins over the port.
  always_comb begin
    if (s.msel == EMB_SEL_256K) begin
      p1_7_out      = s.a17;
      p1_7_oe_n_out = 1'b0;
    end else if (s.wctl[EMB_WCKEN_BIT]) begin
      p1_7_out      = wclk;
      p1_7_oe_n_out = 1'b0;
    end else begin
      p1_7_out      = p1_7_port_in;
      p1_7_oe_n_out = p1_7_port_oe_n_in;
    end
    unique case (s.msel)
      EMB_SEL_256K, EMB_SEL_128K: begin
        p3_7_out      = s.a16;
        p3_7_oe_n_out = 1'b0;
      end
      EMB_SEL_64K_IO: begin
        p3_7_out      = p3_7_port_in;
        p3_7_oe_n_out = p3_7_port_oe_n_in;
      end
      EMB_SEL_64K_CMP: begin
        p3_7_out      = s.rd_n;
        p3_7_oe_n_out = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_wclk_pin;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (s.msel != EMB_SEL_256K && s.wctl[EMB_WCKEN_BIT]) |->
      (p1_7_out == wclk && !p1_7_oe_n_out);
  endproperty
  a_wclk_pin: assert property (p_wclk_pin)
    else $error("wait clock not on port 1 bit 7");

  property p_port_pin_free;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (s.msel == EMB_SEL_64K_IO) |-> (p3_7_out == p3_7_port_in);
  endproperty
  a_port_pin_free: assert property (p_port_pin_free)
    else $error("port 3 bit 7 not freed for code 10");

  property p_compat_prog;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (!s.prog_n && s.msel == EMB_SEL_64K_CMP) |->
      (s.addr > EMB_DATA_TOP_11);
  endproperty
  a_compat_prog: assert property (p_compat_prog)
    else $error("program strobe below 80:0000 in code 11");

  property p_compat_write;
    @(posedge mclk_in) disable iff (sys_rst_in)
    $fell(s.wr_n) && s.msel == EMB_SEL_64K_CMP |->
      (s.addr[23:16] == EMB_SEG_00);
  endproperty
  a_compat_write: assert property (p_compat_write)
    else $error("write strobe outside legacy data in code 11");

  property p_wait_hold;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (s.st == EMB_ST_DATA && s.cnt == 4'h0 && s.wctl[EMB_WTEN_BIT] &&
     !s.wait_s2) |=> (s.st == EMB_ST_DATA && !resp_valid_out);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("bus cycle ended while wait held");

  property p_wait_ignored;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (s.st == EMB_ST_DATA && s.cnt == 4'h0 && !s.wctl[EMB_WTEN_BIT])
      |=> (s.st == EMB_ST_IDLE && resp_valid_out);
  endproperty
  a_wait_ignored: assert property (p_wait_ignored)
    else $error("disabled wait input stretched a cycle");

  property p_page_lanes;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (s.st == EMB_ST_DATA && s.page) |->
      (p0_oe_n_out == 8'h00 && p0_out == s.addr[7:0]);
  endproperty
  a_page_lanes: assert property (p_page_lanes)
    else $error("page mode lost low address on port 0");

  property p_nonpage_lanes;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (s.st == EMB_ST_DATA && !s.page) |->
      (p2_oe_n_out == 8'h00 && p2_out == s.addr[15:8]);
  endproperty
  a_nonpage_lanes: assert property (p_nonpage_lanes)
    else $error("non-page mode lost high address on port 2");

  property p_reserved_quick;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (acc && dec_bus.region == EMB_RGN_RSVD) |=>
      (resp_valid_out && s.st == EMB_ST_IDLE && ale_out == 1'b0);
  endproperty
  a_reserved_quick: assert property (p_reserved_quick)
    else $error("reserved region started a bus cycle");
endmodule
`default_nettype wire

// ---- test/emb_ext_mem_model.sv ----
// External memory model facing the bus decode block.
// Assumes non-page mode: address on port 0 and port 2 while latch is high.
`timescale 1ns/1ps
`default_nettype none
module emb_ext_mem_model (
  input  wire logic       mclk_in,
  input  wire logic       ale_in,
  input  wire logic       rd_n_in,
  input  wire logic [7:0] lo_in,
  input  wire logic [7:0] hi_in,
  input  wire logic [3:0] stall_in,
  output logic      [7:0] data_out,
  output logic            wait_n_out
);
  // ==========================================================
  // Memory and wait
  // ==========================================================
  logic [15:0] addr;
  logic [3:0]  cnt = 4'h0;
  logic [7:0]  d = 8'h00;
  // Released data inverts every cycle so a stale value never passes.
  always_ff @(posedge mclk_in) begin
    if (ale_in) addr <= {hi_in, lo_in};
    d <= rd_n_in ? ~d : addr[7:0] ^ addr[15:8];
    cnt <= ale_in ? stall_in : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
  end
  // Wait stays low while stall cycles remain.
  assign wait_n_out = (cnt == 4'h0);
  assign data_out = d;
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the external memory bus decode block.
// Assumes config byte 04: non-page, remap on, select code 01.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  // Signals
  // ==========================================================
  logic mclk_in = 1'b0, sys_rst_in = 1'b1, req_valid_in = 1'b0;
  logic req_write_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic external_access_n_in = 1'b1, p1_7_port_in = 1'b1;
  logic p1_7_port_oe_n_in = 1'b0, p3_7_port_in = 1'b1;
  logic p3_7_port_oe_n_in = 1'b0, prev;
  logic [7:0] config_byte_zero_in = 8'h04, req_wdata_in = 8'h00;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic [23:0] req_addr_in = 24'h0, resp_addr_out;
  logic [1:0] req_mode_in = 2'h0;
  logic [2:0] resp_region_out;
  logic req_ready_out, resp_valid_out, resp_fault_out, ale_out, wait_n_in;
  logic program_read_strobe_n_out, write_strobe_n_out, p1_7_out;
  logic p1_7_oe_n_out, p3_7_out, p3_7_oe_n_out, ws, ps;
  logic [7:0] resp_rdata_out, reg_rdata_out, p0_in, p0_out, p0_oe_n_out;
  logic [7:0] p2_in, p2_out, p2_oe_n_out;
  logic [3:0] stall = 4'h0;
  int errors = 0, samples_checked = 0, cycles = 0, n;
  emb_ext_memory_bus_decode emb_ext_memory_bus_decode_i (.*);
  emb_ext_mem_model emb_ext_mem_model_i (.mclk_in(mclk_in),
    .ale_in(ale_out), .rd_n_in(program_read_strobe_n_out),
    .lo_in(p0_out), .hi_in(p2_out), .stall_in(stall),
    .data_out(p0_in), .wait_n_out(wait_n_in));
  assign p2_in = ~p0_in;
  // ==========================================================
  // Clock, timeout and tasks
  // ==========================================================
  initial forever #2.5 mclk_in = ~mclk_in;
  // A hang past this many cycles counts as a mismatch.
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task reg_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    chk("reg", {16'h0, e}, {16'h0, reg_rdata_out});
  endtask
  // Latency zero means a stretched cycle: more than eight, against the plain seven.
  task dec(input logic [23:0] a, input logic [1:0] m, input logic [2:0] rg,
           input logic [23:0] ea, input logic f, input int lat);
    while (req_ready_out !== 1'b1) @(negedge mclk_in);
    @(posedge mclk_in);
    req_addr_in <= a;
    req_mode_in <= m;
    req_valid_in <= 1'b1;
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    n = 0;
    ws = 1'b0;
    ps = 1'b0;
    do begin
      @(negedge mclk_in);
      n++;
      ws |= !write_strobe_n_out;
      ps |= !program_read_strobe_n_out;
    end while (resp_valid_out !== 1'b1 && n < 40);
    chk("region", {21'h0, rg}, {21'h0, resp_region_out});
    chk("addr", ea, resp_addr_out);
    chk("fault", {23'h0, f}, {23'h0, resp_fault_out});
    if (lat == 0) chk("stretch", 24'h1, {23'h0, n > 8});
    else chk("latency", 24'(lat), 24'(n));
    if (rg == 3'h3 && !f && !req_write_in) chk("rdata",
      {16'h0, a[7:0] ^ a[15:8]}, {16'h0, resp_rdata_out});
    chk("wr_strobe", {23'h0, req_write_in}, {23'h0, ws});
    chk("prog_rd", {23'h0, rg == 3'h3 && !f && !req_write_in},
        {23'h0, ps});
  endtask
  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    repeat (8) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    reg_chk(8'ha7, 8'h00);
    reg_chk(8'h10, 8'h00);
    dec(24'h000010, 2'h3, 3'h0, 24'h000010, 1'b0, 1);
    dec(24'h00007f, 2'h2, 3'h1, 24'h00007f, 1'b0, 1);
    dec(24'h000080, 2'h2, 3'h1, 24'h000080, 1'b1, 1);
    dec(24'h00041f, 2'h0, 3'h1, 24'h00041f, 1'b0, 1);
    dec(24'h00e000, 2'h1, 3'h2, 24'hff2000, 1'b0, 1);
    dec(24'h020000, 2'h1, 3'h4, 24'h020000, 1'b0, 1);
    dec(24'hfffff8, 2'h1, 3'h5, 24'hfffff8, 1'b0, 1);
    dec(24'hff3fff, 2'h1, 3'h2, 24'hff3fff, 1'b0, 1);
    dec(24'h010000, 2'h0, 3'h3, 24'h010000, 1'b1, 1);
    reg_chk(8'ha8, 8'h11);
    stall <= 4'h8;
    dec(24'h000420, 2'h1, 3'h3, 24'h000420, 1'b0, 7);
    chk("p3_7", 24'h0, {23'h0, p3_7_out});
    chk("p1_7", 24'h1, {23'h0, p1_7_out});
    reg_wr(8'ha7, 8'h03);
    reg_chk(8'ha7, 8'h03);
    dec(24'hff4000, 2'h1, 3'h3, 24'hff4000, 1'b0, 0);
    req_write_in <= 1'b1;
    req_wdata_in <= 8'h5a;
    dec(24'h010005, 2'h1, 3'h3, 24'h010005, 1'b0, 0);
    req_write_in <= 1'b0;
    chk("p3_7", 24'h1, {23'h0, p3_7_out});
    repeat (4) begin
      prev = p1_7_out;
      @(negedge mclk_in);
      chk("wclk", {23'h0, ~prev}, {23'h0, p1_7_out});
    end
    print_verdict;
  end
endmodule
`default_nettype wire
